//--- src/csr_defs.vh
// Functional notes
// - save stores format word at ea, then long words downward from ea plus length.
// - restore reads format word first, then long words upward from ea.
// - word after the format word is filler, carries no state.
// - format word upper byte is status code, lower byte is byte length.
// - code 00 empty/reset, 01 not ready, 02 invalid; length ignored.
// - codes 10 through FF are valid formats with meaningful length.
// - reserved codes 03 through 0F handled exactly like invalid format.
// - save reading empty/reset stores it at ea and finishes.
// - restore of empty/reset writes it, rereads restore register, finishes on empty.
// - save after empty restore yields just format word plus filler word.
// - save not-ready: service pending interrupts, then reread save register.
// - restore not-ready: reread restore register at once, no interrupt service.
// - invalid format during restore: write abort mask, raise format error.
// - abort mask has low two bits 01, upper fourteen bits undefined.
// - no response primitives; status travels only in format words.
// - save begins by reading the save register.
// - invalid format from save register: write abort mask, raise format error.
// - valid length not multiple of four aborts with format error.
// - valid save moves operand register reads into memory until length done.
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH
`define CSR_CODE_EMPTY 8'h00
`define CSR_CODE_NRDY 8'h01
`define CSR_CODE_INVAL 8'h02
`define CSR_CODE_VALID_MIN 8'h10
`define CSR_ABORT_MASK 16'h0001
`define CSR_REG_SAVE 2'h0
`define CSR_REG_RESTORE 2'h1
`define CSR_REG_OPERAND 2'h2
`define CSR_REG_CONTROL 2'h3
`define CSR_FILLER 16'h0000
`define CSR_FIFO_DEPTH 8
`endif

//--- src/csr_fifo.v
`timescale 1ns/1ns
`default_nettype none
module csr_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rst_b,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem[rd_q];
    always @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
    always @(posedge clk) begin
        if (!rst_b) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- src/csr_ctx_engine.v
`timescale 1ns/1ns
`default_nettype none
`include "csr_defs.vh"
// sequencer for context save / restore between the coprocessor interface
// registers (cir_*) and memory (mem_*); one access in flight at a time.
module csr_ctx_engine #(
    parameter AW = 32
) (
    input wire clk,
    input wire rst_b,
    input wire start_save,
    input wire start_restore,
    input wire [AW-1:0] ea,
    input wire irq_pending,
    output reg busy_q,
    output reg done_q,
    output reg fmt_err_q,
    output reg irq_service_q,
    input wire irq_served,
    output reg cir_req_q,
    output reg cir_we_q,
    output reg [1:0] cir_sel_q,
    output reg [31:0] cir_wdata_q,
    input wire cir_ack,
    input wire [31:0] cir_rdata,
    output reg mem_req_q,
    output reg mem_we_q,
    output reg [AW-1:0] mem_addr_q,
    output reg [31:0] mem_wdata_q,
    input wire mem_ack,
    input wire [31:0] mem_rdata
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam S_IDLE = 4'd0;
    localparam S_SV_RD = 4'd1;
    localparam S_SV_IRQ = 4'd2;
    localparam S_SV_FMT = 4'd3;
    localparam S_SV_OP = 4'd4;
    localparam S_SV_MEM = 4'd5;
    localparam S_RS_FMT = 4'd6;
    localparam S_RS_WR = 4'd7;
    localparam S_RS_RD = 4'd8;
    localparam S_RS_MEM = 4'd9;
    localparam S_RS_OP = 4'd10;
    localparam S_ABORT = 4'd11;
    localparam S_DONE = 4'd12;

    reg [3:0] st_q;
    reg [15:0] fmt_q;
    reg [AW-1:0] addr_q;
    reg [7:0] left_q;
    reg restore_q;
    reg f_valid;
    reg [31:0] f_in;
    wire f_ready;
    wire q_valid;
    reg q_ready;
    wire [31:0] q_data;

    // ----------------------------------------
    // format word decode
    // ----------------------------------------
    function [1:0] classify;
        input [15:0] w;
        begin
            if (w[15:8] == `CSR_CODE_EMPTY) begin
                classify = 2'd0;
            end else if (w[15:8] == `CSR_CODE_NRDY) begin
                classify = 2'd1;
            end else if (w[15:8] < `CSR_CODE_VALID_MIN) begin
                classify = 2'd2; // reserved codes count as invalid
            end else if (w[1:0] != 2'b00) begin
                classify = 2'd2; // bad length aborts
            end else begin
                classify = 2'd3;
            end
        end
    endfunction

    // the fifo passes each operand register or memory beat to the other side; the sequencer
    // alternates the two, so it never holds more than a single staging word
    csr_fifo #(.WIDTH(32), .DEPTH(`CSR_FIFO_DEPTH), .AW(3)) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(f_valid),
        .in_ready(f_ready),
        .in_data(f_in),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_data)
    );

    always @* begin
        f_valid = 1'b0;
        f_in = restore_q ? mem_rdata : cir_rdata;
        q_ready = 1'b0;
        if (st_q == S_SV_OP && cir_req_q && cir_ack) begin
            f_valid = 1'b1;
        end
        if (st_q == S_RS_MEM && mem_req_q && mem_ack) begin
            f_valid = 1'b1;
        end
        if (st_q == S_SV_MEM && mem_req_q && mem_ack) begin
            q_ready = 1'b1;
        end
        if (st_q == S_RS_OP && cir_req_q && cir_ack) begin
            q_ready = 1'b1;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always @(posedge clk) begin
        if (!rst_b) begin
            st_q <= S_IDLE;
            fmt_q <= 16'h0000;
            addr_q <= {AW{1'b0}};
            left_q <= 8'h00;
            restore_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            fmt_err_q <= 1'b0;
            irq_service_q <= 1'b0;
            cir_req_q <= 1'b0;
            cir_we_q <= 1'b0;
            cir_sel_q <= 2'h0;
            cir_wdata_q <= 32'h00000000;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= {AW{1'b0}};
            mem_wdata_q <= 32'h00000000;
        end else begin
            done_q <= 1'b0;
            fmt_err_q <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    busy_q <= 1'b0;
                    if (start_save) begin
                        busy_q <= 1'b1;
                        restore_q <= 1'b0;
                        addr_q <= ea;
                        cir_req_q <= 1'b1; // save opens with a read
                        cir_we_q <= 1'b0;
                        cir_sel_q <= `CSR_REG_SAVE;
                        st_q <= S_SV_RD;
                    end else if (start_restore) begin
                        busy_q <= 1'b1;
                        restore_q <= 1'b1;
                        addr_q <= ea;
                        mem_req_q <= 1'b1; // format word first
                        mem_we_q <= 1'b0;
                        mem_addr_q <= ea;
                        st_q <= S_RS_FMT;
                    end
                end
                S_SV_RD: begin
                    if (cir_ack) begin
                        cir_req_q <= 1'b0;
                        fmt_q <= cir_rdata[15:0];
                        case (classify(cir_rdata[15:0]))
                            2'd1: begin
                                irq_service_q <= irq_pending;
                                st_q <= S_SV_IRQ;
                            end
                            2'd2: begin
                                st_q <= S_ABORT;
                            end
                            default: begin
                                // empty and valid both store the format word
                                mem_req_q <= 1'b1;
                                mem_we_q <= 1'b1;
                                mem_addr_q <= addr_q;
                                mem_wdata_q <= {cir_rdata[15:0], `CSR_FILLER};
                                st_q <= S_SV_FMT;
                            end
                        endcase
                    end
                end
                S_SV_IRQ: begin
                    if (!irq_service_q || irq_served) begin
                        irq_service_q <= 1'b0;
                        cir_req_q <= 1'b1; // reread after service
                        st_q <= S_SV_RD;
                    end
                end
                S_SV_FMT: begin
                    if (mem_ack) begin
                        mem_req_q <= 1'b0;
                        if (fmt_q[15:8] == `CSR_CODE_EMPTY || fmt_q[7:0] == 8'h00) begin
                            st_q <= S_DONE; // frame is format plus filler only
                        end else begin
                            left_q <= fmt_q[7:0];
                            addr_q <= addr_q + {{(AW-8){1'b0}}, fmt_q[7:0]};
                            cir_req_q <= 1'b1;
                            cir_sel_q <= `CSR_REG_OPERAND;
                            st_q <= S_SV_OP;
                        end
                    end
                end
                S_SV_OP: begin
                    if (cir_ack) begin
                        cir_req_q <= 1'b0;
                        mem_we_q <= 1'b1;
                        mem_addr_q <= addr_q;
                        st_q <= S_SV_MEM;
                    end
                end
                S_SV_MEM: begin
                    if (!mem_req_q) begin
                        mem_req_q <= q_valid; // operand data to memory
                        mem_wdata_q <= q_data;
                    end else if (mem_ack) begin
                        mem_req_q <= 1'b0;
                        left_q <= left_q - 8'h04;
                        addr_q <= addr_q - {{(AW-3){1'b0}}, 3'h4}; // descending
                        if (left_q == 8'h04) begin
                            st_q <= S_DONE;
                        end else begin
                            cir_req_q <= 1'b1;
                            st_q <= S_SV_OP;
                        end
                    end
                end
                S_RS_FMT: begin
                    if (mem_ack) begin
                        mem_req_q <= 1'b0;
                        fmt_q <= mem_rdata[31:16];
                        cir_req_q <= 1'b1;
                        cir_we_q <= 1'b1;
                        cir_sel_q <= `CSR_REG_RESTORE;
                        cir_wdata_q <= {16'h0000, mem_rdata[31:16]};
                        st_q <= S_RS_WR;
                    end
                end
                S_RS_WR: begin
                    if (cir_ack) begin
                        cir_we_q <= 1'b0; // follow with a read of restore
                        st_q <= S_RS_RD;
                    end
                end
                S_RS_RD: begin
                    if (cir_ack) begin
                        case (classify(cir_rdata[15:0]))
                            2'd0: begin
                                cir_req_q <= 1'b0;
                                st_q <= S_DONE;
                            end
                            2'd1: begin
                                cir_req_q <= 1'b1; // immediate reread
                            end
                            2'd2: begin
                                cir_req_q <= 1'b0;
                                st_q <= S_ABORT;
                            end
                            default: begin
                                cir_req_q <= 1'b0;
                                if (classify(fmt_q) != 2'd3) begin
                                    st_q <= S_ABORT;
                                end else if (fmt_q[7:0] == 8'h00) begin
                                    st_q <= S_DONE;
                                end else begin
                                    left_q <= fmt_q[7:0];
                                    addr_q <= addr_q + {{(AW-3){1'b0}}, 3'h4};
                                    mem_req_q <= 1'b1;
                                    mem_we_q <= 1'b0;
                                    mem_addr_q <= addr_q + {{(AW-3){1'b0}}, 3'h4};
                                    st_q <= S_RS_MEM;
                                end
                            end
                        endcase
                    end
                end
                S_RS_MEM: begin
                    if (mem_ack) begin
                        mem_req_q <= 1'b0;
                        cir_we_q <= 1'b1;
                        cir_sel_q <= `CSR_REG_OPERAND;
                        st_q <= S_RS_OP;
                    end
                end
                S_RS_OP: begin
                    if (!cir_req_q) begin
                        cir_req_q <= q_valid;
                        cir_wdata_q <= q_data;
                    end else if (cir_ack) begin
                        cir_req_q <= 1'b0;
                        cir_we_q <= 1'b0;
                        left_q <= left_q - 8'h04;
                        if (left_q == 8'h04) begin
                            st_q <= S_DONE;
                        end else begin
                            addr_q <= addr_q + {{(AW-3){1'b0}}, 3'h4}; // ascending
                            mem_req_q <= 1'b1;
                            mem_addr_q <= addr_q + {{(AW-3){1'b0}}, 3'h4};
                            st_q <= S_RS_MEM;
                        end
                    end
                end
                S_ABORT: begin
                    if (!cir_req_q) begin
                        cir_req_q <= 1'b1;
                        cir_we_q <= 1'b1;
                        cir_sel_q <= `CSR_REG_CONTROL;
                        cir_wdata_q <= {16'h0000, `CSR_ABORT_MASK};
                    end else if (cir_ack) begin
                        cir_req_q <= 1'b0;
                        cir_we_q <= 1'b0;
                        fmt_err_q <= 1'b1; // format error after abort
                        busy_q <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
                S_DONE: begin
                    done_q <= 1'b1;
                    busy_q <= 1'b0;
                    st_q <= S_IDLE;
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- sim/csr_ctx_engine_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module csr_ctx_chk #(
    parameter AW = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start_save,
    input wire logic start_restore,
    input wire logic [AW-1:0] ea,
    input wire logic busy_q,
    input wire logic done_q,
    input wire logic fmt_err_q,
    input wire logic irq_service_q,
    input wire logic cir_req_q,
    input wire logic cir_we_q,
    input wire logic [1:0] cir_sel_q,
    input wire logic [31:0] cir_wdata_q,
    input wire logic cir_ack,
    input wire logic mem_req_q,
    input wire logic mem_we_q,
    input wire logic [AW-1:0] mem_addr_q,
    input wire logic [31:0] mem_wdata_q,
    input wire logic mem_ack
);
    // ----------------------------
    // which instruction is running
    // ----------------------------
    logic save_q;
    logic first_q;
    logic abort_q;
    logic [AW-1:0] ea_q;
    always @(posedge clk) begin
        if (!rst_b) begin
            save_q <= 1'b0;
            first_q <= 1'b0;
            abort_q <= 1'b0;
            ea_q <= {AW{1'b0}};
        end else if (!busy_q && (start_save || start_restore)) begin
            save_q <= start_save;
            first_q <= 1'b1;
            abort_q <= 1'b0;
            ea_q <= ea;
        end else begin
            if (mem_req_q && mem_ack) first_q <= 1'b0;
            if (cir_req_q && cir_we_q && cir_ack && cir_sel_q == 2'h3) abort_q <= 1'b1;
        end
    end
    // ----------------------------
    // properties
    // ----------------------------
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_cir_req_hold: assert property (
        cir_req_q && !cir_ack |=> cir_req_q && $stable(cir_sel_q) && $stable(cir_we_q)
            && $stable(cir_wdata_q)) else $error("interface access changed before ack");
    a_save_read_first: assert property (
        !busy_q && start_save |=> cir_req_q && !cir_we_q && cir_sel_q == 2'h0)
        else $error("save did not open with a save register read");
    a_restore_read_ea: assert property (
        !busy_q && !start_save && start_restore |=> mem_req_q && !mem_we_q
            && mem_addr_q == $past(ea)) else $error("restore did not open with read at ea");
    a_abort_low_bits: assert property (
        cir_req_q && cir_we_q && cir_sel_q == 2'h3 |-> cir_wdata_q[1:0] == 2'h1)
        else $error("abort mask low bits wrong");
    a_err_after_abort: assert property (
        fmt_err_q |-> abort_q && !cir_req_q && !mem_req_q)
        else $error("format error without prior abort write");
    a_irq_save_only: assert property (
        irq_service_q |-> save_q) else $error("interrupt service during restore");
    a_irq_no_access: assert property (
        irq_service_q |-> !cir_req_q) else $error("save register reread before service");
    a_mem_hold: assert property (
        mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_addr_q) && $stable(mem_we_q)
            && $stable(mem_wdata_q)) else $error("memory access changed before ack");
    a_end_pulse: assert property (
        done_q || fmt_err_q |=> !done_q && !fmt_err_q) else $error("end flag held too long");
    a_first_at_ea: assert property (
        first_q && mem_req_q |-> mem_addr_q == ea_q && mem_we_q == save_q)
        else $error("first memory access not at ea");
    a_filler_zero: assert property (
        first_q && mem_req_q && mem_we_q |-> mem_wdata_q[15:0] == 16'h0000)
        else $error("filler word not zero");
    a_one_access: assert property (
        !(cir_req_q && mem_req_q)) else $error("two accesses in flight");
    c_fmt_err: cover property (fmt_err_q);
    c_irq: cover property (irq_service_q);
    c_save_done: cover property (done_q && save_q);
endmodule

bind csr_ctx_engine csr_ctx_chk #(.AW(AW)) u_chk (
    .clk(clk), .rst_b(rst_b), .start_save(start_save), .start_restore(start_restore),
    .ea(ea), .busy_q(busy_q), .done_q(done_q), .fmt_err_q(fmt_err_q),
    .irq_service_q(irq_service_q), .cir_req_q(cir_req_q), .cir_we_q(cir_we_q),
    .cir_sel_q(cir_sel_q), .cir_wdata_q(cir_wdata_q), .cir_ack(cir_ack),
    .mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q),
    .mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack)
);
`default_nettype wire

//--- sim/csr_copro_model.sv
`timescale 1ns/1ns
`default_nettype none
// coprocessor end: answers by format words only, after a pseudo-random wait
module csr_copro_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cir_req_q,
    input wire logic cir_we_q,
    input wire logic [1:0] cir_sel_q,
    input wire logic [31:0] cir_wdata_q,
    output logic cir_ack,
    output logic [31:0] cir_rdata,
    input wire logic [15:0] save_word,
    input wire logic [1:0] nrdy_n,
    input wire logic work
);
    logic empty_q;
    logic [15:0] rest_q;
    logic [1:0] nr_q;
    logic [7:0] idx_q;
    logic [7:0] lfsr_q;
    logic [15:0] w;
    always @(posedge clk) begin
        if (!rst_b) begin
            empty_q <= 1'b1;
            rest_q <= 16'h0000;
            nr_q <= 2'h0;
            idx_q <= 8'h00;
            lfsr_q <= 8'h5B;
            cir_ack <= 1'b0;
            cir_rdata <= 32'h00000000;
        end else begin
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5]};
            if (work) empty_q <= 1'b0;
            if (cir_ack) begin
                cir_ack <= 1'b0;
                cir_rdata <= ~cir_rdata;
            end else if (cir_req_q && lfsr_q[0]) begin
                cir_ack <= 1'b1;
                if (cir_we_q && cir_sel_q == 2'h1) begin
                    rest_q <= cir_wdata_q[15:0];
                    nr_q <= 2'h0;
                    if (cir_wdata_q[15:8] == 8'h00) empty_q <= 1'b1;
                    if (cir_wdata_q[15:8] >= 8'h10) empty_q <= 1'b0;
                end else if (cir_we_q && cir_sel_q == 2'h3) begin
                    idx_q <= 8'h00;
                end else if (!cir_we_q && cir_sel_q == 2'h2) begin
                    idx_q <= idx_q + 8'h01;
                    cir_rdata <= 32'h5A000000 + {24'h000000, idx_q};
                end else if (!cir_we_q) begin
                    // a not-ready streak is set by the bench, for save and restore alike
                    if (nr_q < nrdy_n) w = 16'h0100;
                    else if (cir_sel_q == 2'h0) w = empty_q ? 16'h0000 : save_word;
                    else if (rest_q[15:8] == 8'h00 || rest_q[15:8] >= 8'h10) w = rest_q;
                    else w = 16'h0200;
                    nr_q <= (w == 16'h0100) ? nr_q + 2'h1 : 2'h0;
                    if (w[15:8] >= 8'h10) idx_q <= 8'h00;
                    cir_rdata <= {16'hFFFF, w};
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/tb_coproc_context_save_restore.sv
`timescale 1ns/1ns
`default_nettype none
module tb_coproc_context_save_restore;
    logic clk, rst_b, start_save, start_restore, irq_pending, irq_served, work;
    logic busy_q, done_q, fmt_err_q, irq_service_q;
    logic cir_req_q, cir_we_q, cir_ack, mem_req_q, mem_we_q, mem_ack;
    logic [1:0] cir_sel_q, nrdy_n;
    logic [31:0] ea, cir_wdata_q, cir_rdata, mem_addr_q, mem_wdata_q, mem_rdata;
    logic [15:0] save_word;
    logic [7:0] rc;
    logic [31:0] mem [logic [31:0]];
    logic [63:0] exp_q [$];
    logic emp, fin, irq_seen;
    integer seed, fails, total_checks, dly, n;
    integer cyc = 0;
    csr_ctx_engine #(.AW(32)) uut (.clk(clk), .rst_b(rst_b), .start_save(start_save),
        .start_restore(start_restore), .ea(ea), .irq_pending(irq_pending), .busy_q(busy_q),
        .done_q(done_q), .fmt_err_q(fmt_err_q), .irq_service_q(irq_service_q),
        .irq_served(irq_served), .cir_req_q(cir_req_q), .cir_we_q(cir_we_q),
        .cir_sel_q(cir_sel_q), .cir_wdata_q(cir_wdata_q), .cir_ack(cir_ack),
        .cir_rdata(cir_rdata), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q),
        .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    csr_copro_model partner (.clk(clk), .rst_b(rst_b), .cir_req_q(cir_req_q),
        .cir_we_q(cir_we_q), .cir_sel_q(cir_sel_q), .cir_wdata_q(cir_wdata_q),
        .cir_ack(cir_ack), .cir_rdata(cir_rdata), .save_word(save_word), .nrdy_n(nrdy_n),
        .work(work));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
        total_checks = total_checks + 1;
        if (seen !== want) begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic note(input logic [63:0] seen);
        logic [63:0] want;
        want = (exp_q.size() > 0) ? exp_q.pop_front() : 64'h0;
        check("transfer", seen, want);
    endtask
    task automatic close_out;
        check("leftover", 64'(exp_q.size()), 64'h0);
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // --------------------------------
    // memory, interrupt host, timeout
    // --------------------------------
    always @(posedge clk) begin
        cyc = cyc + 1;
        #1;
        irq_served = irq_service_q && !irq_served;
        if (irq_service_q) irq_seen = 1'b1;
        if (mem_ack) begin
            mem_ack = 1'b0;
            mem_rdata = ~mem_rdata;
            dly = $random(seed) & 1;
        end else if (mem_req_q && dly > 0) begin
            dly = dly - 1;
        end else if (mem_req_q) begin
            mem_ack = 1'b1;
            if (mem_we_q) mem[mem_addr_q] = mem_wdata_q;
            else mem_rdata = mem[mem_addr_q];
        end
        if (cyc == 20000) begin
            fails = fails + 1;
            close_out;
        end
    end
    // ----------------
    // result watcher
    // ----------------
    always @(posedge clk) begin
        if (rst_b && mem_req_q && mem_we_q && mem_ack) note({mem_addr_q, mem_wdata_q});
        if (rst_b && cir_req_q && cir_we_q && cir_ack && cir_sel_q == 2'h2)
            note({32'hFFFFFFF2, cir_wdata_q});
        if (rst_b && cir_req_q && cir_we_q && cir_ack && cir_sel_q == 2'h3)
            note({32'hFFFFFFF3, 30'h0, cir_wdata_q[1:0]});
        if (rst_b && done_q) note(64'hFFFFFFFF_00000001);
        if (rst_b && fmt_err_q) note(64'hFFFFFFFF_00000002);
        if (done_q || fmt_err_q) fin = 1'b1;
    end
    // one save or restore; expectations follow from the format word and the empty flag emp
    task automatic op(input logic sv, input logic [15:0] fw);
        logic [15:0] w;
        logic bad;
        integer k;
        ea = $random(seed) & 32'h0FFFFFFC;
        save_word = fw;
        w = (sv && emp) ? 16'h0000 : fw;
        bad = w[15:8] != 8'h00 && (w[15:8] < 8'h10 || w[1:0] != 2'h0);
        if (!sv) mem[ea] = {fw, 16'h0000};
        if (!sv && w[15:8] == 8'h00) emp = 1'b1;
        if (!sv && w[15:8] >= 8'h10) emp = 1'b0;
        if (sv && !bad) exp_q.push_back({ea, w, 16'h0000});
        for (k = 0; !bad && w[15:8] >= 8'h10 && k < w[7:0] / 4; k++) begin
            if (sv) begin
                exp_q.push_back({ea + w[7:0] - 4 * k, 32'h5A000000 + k});
            end else begin
                mem[ea + 4 * k + 4] = $random(seed);
                exp_q.push_back({32'hFFFFFFF2, mem[ea + 4 * k + 4]});
            end
        end
        if (bad) exp_q.push_back({32'hFFFFFFF3, 32'h00000001});
        exp_q.push_back(bad ? 64'hFFFFFFFF_00000002 : 64'hFFFFFFFF_00000001);
        fin = 1'b0;
        irq_seen = 1'b0;
        start_save = sv;
        start_restore = !sv;
        @(posedge clk);
        #1;
        start_save = 1'b0;
        start_restore = 1'b0;
        check("busy", busy_q, 1'b1);
        wait (fin);
        @(posedge clk);
        #1;
    endtask
    initial begin
        seed = 16630;
        fails = 0;
        total_checks = 0;
        {rst_b, start_save, start_restore, irq_pending, irq_served, work, mem_ack} = 7'h00;
        {ea, mem_rdata, dly} = 96'h0;
        {save_word, nrdy_n, emp, fin, irq_seen} = {16'h1008, 2'h0, 3'h4};
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        op(1'b1, 16'h1008);
        work = 1'b1;
        @(posedge clk);
        #1;
        work = 1'b0;
        emp = 1'b0;
        nrdy_n = 2'h2;
        irq_pending = 1'b1;
        op(1'b1, 16'h3C08);
        check("irq service", irq_seen, 1'b1);
        nrdy_n = 2'h0;
        for (n = 2; n < 16; n++) op(1'b1, {n[7:0], 8'h08});
        op(1'b1, 16'h1006);
        op(1'b1, 16'hFF00);
        op(1'b0, 16'h0000);
        op(1'b1, 16'h2010);
        nrdy_n = 2'h1;
        op(1'b0, 16'h770C);
        check("irq service", irq_seen, 1'b0);
        nrdy_n = 2'h0;
        op(1'b0, 16'h0504);
        op(1'b0, 16'h4006);
        for (n = 0; n < 6; n++) begin
            rc = 8'h10 + 8'($random(seed) & 32'h7F);
            op(1'($random(seed)), {rc, 8'($random(seed) & 32'h1C)});
        end
        close_out;
    end
endmodule
`default_nettype wire
